// file: logic/rps_pkg.sv
// Constants and carrier types for the remappable pin select block
// Notes on behaviour
// - Each peripheral input owns a selector naming the pin it receives.
// - Input selectors are 8 bits; value n connects remappable pin n.
// - Legal input codes stop at the number of pins implemented.
// - Input code zero ties the peripheral input to constant low.
// - Input code 181 selects pin 181, code 1 selects pin 1.
// - Pins 176 to 181 are internal virtual pins; with no output routed they read the port default, not a pad.
// - An output routed to a virtual pin is seen by inputs naming it.
// - Each pin has a 6-bit output selector; zero keeps default port logic.
// - Output codes 1 to 4: serial1 tx, serial1 rts, serial2 tx, serial2 rts.
// - Output codes 5, 6, 7: first SPI data, clock, select.
// - Output codes 8, 9, 10: second SPI data, clock, select.
// - Output codes 16 to 19: compare outputs a to d.
// - Output codes 24 to 26: comparators a to c; comparator d uses 50.
// - Output code 45 primary timebase sync, 46 secondary timebase sync.
// - Output code 49 drives the reference clock output.
// - Output codes 51 to 54: pwm d high, d low, e high, e low.
// - First input map: spi clock selector bits 15:8, data selector 7:0.
// - Second input map: select selector bits 7:0; bits 15:8 read zero.
package rps_pkg;

  localparam int NUM_PINS      = 182;
  localparam int IN_SEL_W      = 8;
  localparam int OUT_SEL_W     = 6;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 16;

  // Register map (word index = address)
  localparam logic [7:0] ADDR_IN_MAP_CD  = 8'h00;
  localparam logic [7:0] ADDR_IN_MAP_SEL = 8'h01;
  localparam logic [7:0] ADDR_OUT_BASE   = 8'h10;
  localparam logic [7:0] ADDR_PIN_LO     = 8'h08;
  localparam logic [7:0] PIN_WORDS       = 8'h0C;

  localparam int CD_CLK_LSB    = 8;
  localparam int CD_DATA_LSB   = 0;
  localparam logic [15:0] IN_MAP_RESET = 16'h0000;
  localparam logic [5:0]  OUT_SEL_RESET = 6'h00;

  // Output selector codes
  localparam logic [5:0] OS_DEFAULT  = 6'h00;
  localparam logic [5:0] OS_SER1_TX  = 6'h01;
  localparam logic [5:0] OS_SER1_RTS = 6'h02;
  localparam logic [5:0] OS_SER2_TX  = 6'h03;
  localparam logic [5:0] OS_SER2_RTS = 6'h04;
  localparam logic [5:0] OS_SPIA_DO  = 6'h05;
  localparam logic [5:0] OS_SPIA_CK  = 6'h06;
  localparam logic [5:0] OS_SPIA_SS  = 6'h07;
  localparam logic [5:0] OS_SPIB_DO  = 6'h08;
  localparam logic [5:0] OS_SPIB_CK  = 6'h09;
  localparam logic [5:0] OS_SPIB_SS  = 6'h0A;
  localparam logic [5:0] OS_CMPO_A   = 6'h10;
  localparam logic [5:0] OS_CMPO_B   = 6'h11;
  localparam logic [5:0] OS_CMPO_C   = 6'h12;
  localparam logic [5:0] OS_CMPO_D   = 6'h13;
  localparam logic [5:0] OS_ACMP_A   = 6'h18;
  localparam logic [5:0] OS_ACMP_B   = 6'h19;
  localparam logic [5:0] OS_ACMP_C   = 6'h1A;
  localparam logic [5:0] OS_SYNC_P   = 6'h2D;
  localparam logic [5:0] OS_SYNC_S   = 6'h2E;
  localparam logic [5:0] OS_REFCLK   = 6'h31;
  localparam logic [5:0] OS_ACMP_D   = 6'h32;
  localparam logic [5:0] OS_PWMD_H   = 6'h33;
  localparam logic [5:0] OS_PWMD_L   = 6'h34;
  localparam logic [5:0] OS_PWME_H   = 6'h35;
  localparam logic [5:0] OS_PWME_L   = 6'h36;

  typedef struct packed {
    logic ser1_tx;
    logic ser1_rts;
    logic ser2_tx;
    logic ser2_rts;
    logic spia_do;
    logic spia_ck;
    logic spia_ss;
    logic spib_do;
    logic spib_ck;
    logic spib_ss;
    logic [3:0] cmp_out;
    logic [3:0] acmp_out;
    logic sync_p;
    logic sync_s;
    logic refclk;
    logic pwmd_h;
    logic pwmd_l;
    logic pwme_h;
    logic pwme_l;
  } rps_periph_out_t;

  typedef struct packed {
    logic spia_clk_in;
    logic spia_data_in;
    logic spia_sel_in;
  } rps_periph_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rps_bus_req_t;

endpackage

// file: logic/rps_sel_mem.sv
// Register array of per-pin output selectors with registered read port
`timescale 1ns/1ps
module rps_sel_mem #(
  parameter int DEPTH = 182,
  parameter int WIDTH = 6
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     we_i,
  input  wire logic [7:0]               waddr_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  input  wire logic [7:0]               raddr_i,
  output logic      [WIDTH-1:0]         rdata_o,
  output logic      [DEPTH*WIDTH-1:0]   all_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // Every selector is visible at once since each pin mux reads its own
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cell
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          mem_r[g] <= rps_pkg::OUT_SEL_RESET;
        end else if (we_i && (waddr_i == 8'(g))) begin
          mem_r[g] <= wdata_i;
        end
      end
      assign all_o[g*WIDTH +: WIDTH] = mem_r[g];
    end
  endgenerate

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (int'(raddr_i) < DEPTH) begin
      rdata_o <= mem_r[raddr_i];
    end else begin
      rdata_o <= '0;
    end
  end

endmodule

// file: logic/rps_top.sv
// Remappable pin select: input and output routing with register port
`timescale 1ns/1ps
module rps_top #(
  parameter int NUM_PINS  = rps_pkg::NUM_PINS,
  parameter int NUM_PADS  = 176
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_i,
  input  wire logic [7:0]                   addr_i,
  input  wire logic [15:0]                  wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [15:0]                  rdata_o,
  input  wire logic [NUM_PADS-1:0]          pad_in_i,
  input  wire logic [NUM_PINS-1:0]          port_default_i,
  input  wire rps_pkg::rps_periph_out_t     periph_out_i,
  output rps_pkg::rps_periph_in_t           periph_in_o,
  output logic      [NUM_PADS-1:0]          pad_out_o,
  output logic      [NUM_PADS-1:0]          pad_remapped_o
);

  // Address map: 0x00 and 0x01 are the input maps; 0x10 + n is pin n's selector
  localparam int OUT_SEL_W = rps_pkg::OUT_SEL_W;

  rps_pkg::rps_bus_req_t req;
  logic [15:0]                 in_map_cd_r;
  logic [7:0]                  in_map_sel_r;
  logic [NUM_PINS*OUT_SEL_W-1:0] out_sel_all;
  logic                        out_hit;
  logic [7:0]                  out_idx;
  logic [NUM_PINS-1:0]         pin_val;
  logic [NUM_PINS-1:0]         pin_rem;

  assign req.addr  = addr_i;
  assign req.wdata = wdata_i;
  assign req.wr    = wr_i;
  assign req.rd    = rd_i;

  assign out_idx = req.addr - rps_pkg::ADDR_OUT_BASE;
  assign out_hit = (req.addr >= rps_pkg::ADDR_OUT_BASE) && (int'(out_idx) < NUM_PINS);

  // Input selectors, one field per peripheral input
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      in_map_cd_r <= rps_pkg::IN_MAP_RESET;
    end else if (req.wr && req.addr == rps_pkg::ADDR_IN_MAP_CD) begin
      in_map_cd_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      in_map_sel_r <= 8'h00;
    end else if (req.wr && req.addr == rps_pkg::ADDR_IN_MAP_SEL) begin
      in_map_sel_r <= req.wdata[7:0];
    end
  end

  rps_sel_mem #(
    .DEPTH (NUM_PINS),
    .WIDTH (OUT_SEL_W)
  ) u_sel_mem (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .we_i      (req.wr && out_hit),
    .waddr_i   (out_idx),
    .wdata_i   (req.wdata[OUT_SEL_W-1:0]),
    .raddr_i   (out_idx),
    .rdata_o   (),
    .all_o     (out_sel_all)
  );

  // Output function decode; unlisted codes fall back to the port
  function automatic logic [1:0] out_pick(input logic [5:0] code,
                                          input rps_pkg::rps_periph_out_t p,
                                          input logic dflt);
    logic v;
    logic r;
    v = dflt;
    r = 1'b1;
    unique case (code)
      rps_pkg::OS_SER1_TX:  v = p.ser1_tx;
      rps_pkg::OS_SER1_RTS: v = p.ser1_rts;
      rps_pkg::OS_SER2_TX:  v = p.ser2_tx;
      rps_pkg::OS_SER2_RTS: v = p.ser2_rts;
      rps_pkg::OS_SPIA_DO:  v = p.spia_do;
      rps_pkg::OS_SPIA_CK:  v = p.spia_ck;
      rps_pkg::OS_SPIA_SS:  v = p.spia_ss;
      rps_pkg::OS_SPIB_DO:  v = p.spib_do;
      rps_pkg::OS_SPIB_CK:  v = p.spib_ck;
      rps_pkg::OS_SPIB_SS:  v = p.spib_ss;
      rps_pkg::OS_CMPO_A:   v = p.cmp_out[0];
      rps_pkg::OS_CMPO_B:   v = p.cmp_out[1];
      rps_pkg::OS_CMPO_C:   v = p.cmp_out[2];
      rps_pkg::OS_CMPO_D:   v = p.cmp_out[3];
      rps_pkg::OS_ACMP_A:   v = p.acmp_out[0];
      rps_pkg::OS_ACMP_B:   v = p.acmp_out[1];
      rps_pkg::OS_ACMP_C:   v = p.acmp_out[2];
      rps_pkg::OS_ACMP_D:   v = p.acmp_out[3];
      rps_pkg::OS_SYNC_P:   v = p.sync_p;
      rps_pkg::OS_SYNC_S:   v = p.sync_s;
      rps_pkg::OS_REFCLK:   v = p.refclk;
      rps_pkg::OS_PWMD_H:   v = p.pwmd_h;
      rps_pkg::OS_PWMD_L:   v = p.pwmd_l;
      rps_pkg::OS_PWME_H:   v = p.pwme_h;
      rps_pkg::OS_PWME_L:   v = p.pwme_l;
      default: begin
        v = dflt;
        r = 1'b0;
      end
    endcase
    return {r, v};
  endfunction

  // Pin level as seen by inputs; virtual pins carry the routed output, or the port default when none is routed
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      logic [1:0] pick;
      assign pick = out_pick(out_sel_all[g*OUT_SEL_W +: OUT_SEL_W], periph_out_i,
                             port_default_i[g]);
      assign pin_rem[g] = pick[1];
      if (g >= NUM_PADS) begin : g_virt
        assign pin_val[g] = pick[0];
      end else begin : g_phys
        // A pad driven by a peripheral reads back its own drive
        assign pin_val[g] = pick[1] ? pick[0] : pad_in_i[g];
      end
    end
  endgenerate

  // Input decode: zero and out-of-range codes give low
  function automatic logic in_pick(input logic [7:0] code,
                                   input logic [NUM_PINS-1:0] pins);
    logic v;
    v = 1'b0;
    if (code != 8'h00 && int'(code) < NUM_PINS) begin
      v = pins[code];
    end
    return v;
  endfunction

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      periph_in_o <= '0;
    end else begin
      periph_in_o.spia_clk_in  <= in_pick(in_map_cd_r[15:8], pin_val);
      periph_in_o.spia_data_in <= in_pick(in_map_cd_r[7:0], pin_val);
      periph_in_o.spia_sel_in  <= in_pick(in_map_sel_r, pin_val);
    end
  end

  // Registered pad drive; one cycle later than the selector write
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_o      <= '0;
      pad_remapped_o <= '0;
    end else begin
      pad_out_o      <= pin_val[NUM_PADS-1:0];
      pad_remapped_o <= pin_rem[NUM_PADS-1:0];
    end
  end

  // Read data straight from a flop; selectors come from the flat copy, not the slow port
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= 16'h0000;
      if (req.rd) begin
        if (req.addr == rps_pkg::ADDR_IN_MAP_CD) begin
          rdata_o <= in_map_cd_r;
        end else if (req.addr == rps_pkg::ADDR_IN_MAP_SEL) begin
          rdata_o <= {8'h00, in_map_sel_r};
        end else if (out_hit) begin
          rdata_o <= {10'h000, out_sel_all[int'(out_idx)*OUT_SEL_W +: OUT_SEL_W]};
        end
      end
    end
  end

  chk_in_ground_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (in_map_sel_r == 8'h00) |=> !periph_in_o.spia_sel_in)
    else $error("select input not grounded at code zero");

  chk_sel_hi_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == rps_pkg::ADDR_IN_MAP_SEL) |=> (rdata_o[15:8] == 8'h00))
    else $error("unimplemented bits read nonzero");

  chk_cd_write_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == rps_pkg::ADDR_IN_MAP_CD) ##1
    (rd_i && addr_i == rps_pkg::ADDR_IN_MAP_CD) |=> (rdata_o == $past(wdata_i, 2)))
    else $error("input map readback mismatch");

  chk_virt_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (in_map_sel_r == 8'd176 && out_sel_all[176*OUT_SEL_W +: OUT_SEL_W] ==
     rps_pkg::OS_ACMP_A) |=> (periph_in_o.spia_sel_in == $past(periph_out_i.acmp_out[0])))
    else $error("virtual pin route lost");

  chk_pin1_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (in_map_cd_r[7:0] == 8'h01) |=> (periph_in_o.spia_data_in == $past(pin_val[1])))
    else $error("code one did not route pin one");

  chk_pin181_clk: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (in_map_cd_r[15:8] == 8'hB5) |=> (periph_in_o.spia_clk_in == $past(pin_val[181])))
    else $error("top code did not route pin 181");

  chk_out_default: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (out_sel_all[3*OUT_SEL_W +: OUT_SEL_W] == rps_pkg::OS_DEFAULT) |=> !pad_remapped_o[3])
    else $error("default code marked remapped");

  chk_out_ser1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (out_sel_all[3*OUT_SEL_W +: OUT_SEL_W] == rps_pkg::OS_SER1_TX) |=>
    (pad_remapped_o[3] && pad_out_o[3] == $past(periph_out_i.ser1_tx)))
    else $error("serial transmit not on pad");

  chk_out_unused: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (out_sel_all[3*OUT_SEL_W +: OUT_SEL_W] == 6'h0B) |=>
    (!pad_remapped_o[3] && pad_out_o[3] == $past(pad_in_i[3])))
    else $error("unassigned code did not default");

endmodule

// file: dv/rps_far_model.sv
// Far-side model: peripheral output levels, pad levels and default port values
`timescale 1ns/1ps
module rps_far_model (
  input  wire logic                 clk_sys_i,
  input  wire logic [31:0]          word_i,
  output rps_pkg::rps_periph_out_t  periph_out_o,
  output logic      [175:0]         pad_in_o,
  output logic      [181:0]         port_default_o
);
  // Levels move only on a clock edge, as from clocked peripherals
  logic [31:0]  word_r = 32'h0000_0000;
  logic [191:0] spread;
  always @(posedge clk_sys_i) word_r <= word_i;
  // Defaults shifted and inverted so a swapped source shows up
  assign spread = {6{word_r}};
  assign periph_out_o = word_r[24:0];
  assign pad_in_o = spread[175:0];
  assign port_default_o = ~spread[191:10];
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the remappable pin select block
`timescale 1ns/1ps
module tb_top;
  logic                     clk_sys_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic [7:0]               addr = 8'h00;
  logic [15:0]              wdata = 16'h0000;
  logic                     wr = 1'b0;
  logic                     rd = 1'b0;
  logic [15:0]              rdata;
  logic [175:0]             pad_in;
  logic [175:0]             pad_out;
  logic [175:0]             pad_rm;
  logic [181:0]             dflt;
  rps_pkg::rps_periph_out_t pout;
  rps_pkg::rps_periph_in_t  pin;
  logic [31:0]              rnd = 32'h0000_2644;
  logic [31:0]              far_w = 32'h0000_0000;
  logic [5:0]               osel [182];
  logic [23:0]              isel;
  logic [15:0]              exp_q [$];
  logic                     rd_seen = 1'b0;
  logic                     smp = 1'b0;
  int                       smp_k = 0;
  int                       n;
  int                       fail_count = 0;
  int                       n_tests = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  rps_far_model FAR (.clk_sys_i(clk_sys_i), .word_i(far_w), .periph_out_o(pout),
                     .pad_in_o(pad_in), .port_default_o(dflt));
  rps_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
               .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pad_in_i(pad_in),
               .port_default_i(dflt), .periph_out_i(pout), .periph_in_o(pin),
               .pad_out_o(pad_out), .pad_remapped_o(pad_rm));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Returns {assigned, level} for an output code
  function automatic logic [1:0] route(input int c);
    logic [24:0] v;
    v = pout;
    if (c >= 1 && c <= 10) return {1'b1, v[25-c]};
    if (c >= 16 && c <= 19) return {1'b1, pout.cmp_out[c-16]};
    if (c >= 24 && c <= 26) return {1'b1, pout.acmp_out[c-24]};
    case (c)
      45: return {1'b1, pout.sync_p};
      46: return {1'b1, pout.sync_s};
      49: return {1'b1, pout.refclk};
      50: return {1'b1, pout.acmp_out[3]};
      51, 52, 53, 54: return {1'b1, v[54-c]};
      default: return 2'b00;
    endcase
  endfunction

  function automatic logic in_exp(input int code);
    logic [1:0] r;
    if (code == 0 || code > 181) return 1'b0;
    r = route(osel[code]);
    if (r[1]) return r[0];
    return (code < 176) ? pad_in[code] : dflt[code];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    exp_q.push_back(e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
  endtask

  task automatic idle(input int k);
    repeat (k) begin
      @(posedge clk_sys_i);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask

  task automatic stir();
    @(posedge clk_sys_i);
    rnd = xs(rnd);
    far_w <= rnd;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic set_os(input int p, input logic [5:0] c);
    wr_reg(8'h10 + p[7:0], {10'h000, c});
    osel[p] = c;
  endtask

  task automatic set_in(input logic [7:0] c, input logic [7:0] d, input logic [7:0] s);
    wr_reg(8'h00, {c, d});
    wr_reg(8'h01, {8'h00, s});
    isel = {c, d, s};
  endtask

  // Waits for levels to settle, then notes routed inputs and pad k
  task automatic sample(input int k);
    logic [1:0] r;
    idle(3);
    r = route(osel[k]);
    exp_q.push_back({11'h000, in_exp(isel[23:16]), in_exp(isel[15:8]),
                     in_exp(isel[7:0]), r[1] ? r[0] : pad_in[k], r[1]});
    smp_k <= k;
    smp <= 1'b1;
    @(posedge clk_sys_i);
    smp <= 1'b0;
  endtask

  always @(posedge clk_sys_i) rd_seen <= rd;

  always @(negedge clk_sys_i) begin
    if (rd_seen) begin
      chk(rdata, exp_q.size() ? exp_q.pop_front() : ~rdata);
    end
    if (smp) begin
      chk({11'h000, pin, pad_out[smp_k], pad_rm[smp_k]},
          exp_q.size() ? exp_q.pop_front() : 16'h0000);
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    summarize();
  end

  initial begin
    for (int i = 0; i < 182; i++) osel[i] = 6'h00;
    isel = 24'h00_0000;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_reg(8'h00, 16'h0000);
    rd_reg(8'h01, 16'h0000);
    rd_reg(8'h15, 16'h0000);
    wr_reg(8'h05, 16'hFFFF);
    rd_reg(8'h05, 16'h0000);
    stir();
    wr_reg(8'h00, rnd[15:0]);
    rd_reg(8'h00, rnd[15:0]);
    wr_reg(8'h01, 16'hFFB5);
    rd_reg(8'h01, 16'h00B5);
    set_in(8'h03, 8'h00, 8'hC8);
    for (int c = 0; c < 64; c++) begin
      stir();
      set_os(3, c[5:0]);
      rd_reg(8'h13, {10'h000, c[5:0]});
      sample(3);
    end
    // Comparator onto a virtual pin, picked up by the select input
    set_os(176, 6'h18);
    set_os(181, 6'h00);
    set_os(1, 6'h00);
    set_in(8'hB5, 8'h01, 8'hB0);
    repeat (4) begin
      stir();
      sample(1);
    end
    for (int i = 0; i < 24; i++) begin
      stir();
      n = 1 + rnd[15:8] % 181;
      set_os(n, rnd[21:16]);
      set_in(rnd[7:0], rnd[31:24], n[7:0]);
      sample(n % 176);
    end
    idle(2);
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) idle(1);
    if (exp_q.size() != 0) fail_count++;
    summarize();
  end
endmodule
